// ==== hw/hvms_map.vh ====
// constants for the high-voltage measurement switch control block
`ifndef HVMS_MAP_VH
`define HVMS_MAP_VH
// ----------------------------------------
// chip operating modes
// ----------------------------------------
`define HVMS_MODE_W        3
`define HVMS_MODE_NORMAL   3'h0
`define HVMS_MODE_STOP     3'h1
`define HVMS_MODE_SLEEP    3'h2
`define HVMS_MODE_RESTART  3'h3
`define HVMS_MODE_FAILSAFE 3'h4
`define HVMS_MODE_INIT     3'h5
// ----------------------------------------
// io pin configuration codes
// ----------------------------------------
`define HVMS_IOCFG_W       3
`define HVMS_IOCFG_FAIL    3'h0
`define HVMS_IOCFG_OFF     3'h4
`define HVMS_IOCFG_WAKE    3'h5
// ----------------------------------------
// reset values
// ----------------------------------------
`define HVMS_MEAS_RST      1'h0
`define HVMS_SYNC_RST      3'h0
`endif

// ==== hw/hvms_sync.v ====
// three-stage pin input synchroniser with agreement filter
`include "hvms_map.vh"
module hvms_sync (
    // clock and reset
    input  wire clk,
    input  wire rst_n,
    // pin and result
    input  wire pin_in,
    output reg  level_out
);
    reg [2:0] sync_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_reg  <= `HVMS_SYNC_RST;
            level_out <= 1'h0;
        end else begin
            sync_reg <= {sync_reg[1:0], pin_in};
            // stage 0 is only read by stage 1
            if (sync_reg[1] == sync_reg[2])
                level_out <= sync_reg[2];
        end
    end
endmodule

// ==== hw/hvms_ctrl.v ====
// high-voltage measurement switch control and pin function gating
//
// Notes on behaviour
// - reset leaves measurement off, switch open
// - enable written one closes switch in Normal
// - other modes open switch, keep enable stored
// - enabled: pulls off, pin inputs gated
// - enabled: pull/wake/io config accepted but ignored
// - enabled: wake and level status not updated
// - enabled: sleep with only pin wakes: error, Restart
// - enabled: wake enables writable, cause no wake-up
// - enabled: no fail output, test, gpio, wake
// - enabled: io config change sets error flag
// - enable refused unless io pin is Off
// - fail-safe with enable: kept, switch open
// - fail-safe without enable: sense pin wakes
// - measurement only active in Normal mode
`include "hvms_map.vh"
module hvms_ctrl (
    // clock and reset
    input  wire                      REF_CLK,
    input  wire                      RESET_N,
    // chip mode from mode controller
    input  wire [`HVMS_MODE_W-1:0]   CHIP_MODE,
    // spi write of measure_enable
    input  wire                      MEAS_WR,
    input  wire                      MEAS_WR_DATA,
    // io pin configuration write attempt
    input  wire                      IOCFG_WR,
    input  wire [`HVMS_IOCFG_W-1:0]  IOCFG_WR_DATA,
    input  wire [`HVMS_IOCFG_W-1:0]  IOCFG_CUR,
    // stored pin settings (written freely, possibly ignored)
    input  wire                      SENSE_WAKE_ENABLE,
    input  wire [1:0]                SENSE_PULL_CFG,
    input  wire [1:0]                IO_PULL_CFG,
    input  wire                      FAIL_OUTPUT_REQ,
    input  wire                      FAIL_OUTPUT_TEST,
    input  wire                      IO_OUT_REQ,
    input  wire                      OTHER_WAKE_SRC,
    // sleep command
    input  wire                      SLEEP_CMD,
    // raw pin levels
    input  wire                      HV_SENSE_PIN,
    input  wire                      FAIL_OUTPUT_IO_PIN_I,
    // switch and pin control
    output wire                      MEASURE_SWITCH,
    output wire [1:0]                SENSE_PULL_EN,
    output wire [1:0]                IO_PULL_EN,
    output reg                       FAIL_OUTPUT_IO_PIN_O,
    output reg                       FAIL_OUTPUT_IO_PIN_OE,
    // gated pin signals toward wake logic
    output reg                       SENSE_LEVEL,
    output reg                       IO_LEVEL,
    output wire                      WAKE_STATUS_UPDATE_EN,
    output wire                      SENSE_WAKE_ACTIVE,
    output wire                      IO_WAKE_ACTIVE,
    // status
    output wire                      MEASURE_ENABLE,
    output reg                       SPI_FAIL_SET,
    output reg                       RESTART_REQ
);
    // ----------------------------------------
    // enable bit
    // ----------------------------------------
    reg  measure_enable_reg;
    reg  measure_enable_next;
    wire io_off   = (IOCFG_CUR == `HVMS_IOCFG_OFF);
    wire is_norm  = (CHIP_MODE == `HVMS_MODE_NORMAL);
    wire is_fsafe = (CHIP_MODE == `HVMS_MODE_FAILSAFE);
    wire io_wake  = (IOCFG_CUR == `HVMS_IOCFG_WAKE);
    wire refuse   = MEAS_WR & MEAS_WR_DATA & ~io_off & ~measure_enable_reg;

    always @* begin
        measure_enable_next = measure_enable_reg;
        if (MEAS_WR && !refuse)
            measure_enable_next = MEAS_WR_DATA;
    end

    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N)
            measure_enable_reg <= `HVMS_MEAS_RST;
        else
            measure_enable_reg <= measure_enable_next;
    end

    assign MEASURE_ENABLE = measure_enable_reg;

    // ----------------------------------------
    // switch
    // ----------------------------------------
    // closed only in normal mode so no divider current flows when idle
    assign MEASURE_SWITCH = measure_enable_reg & is_norm;

    // ----------------------------------------
    // pulls
    // ----------------------------------------
    reg  [1:0] sense_pull_sel;
    reg  [1:0] io_pull_sel;

    always @* begin
        sense_pull_sel = SENSE_PULL_CFG;
        io_pull_sel    = IO_PULL_CFG;
        if (measure_enable_reg) begin
            // stored settings stay as written, only their effect drops
            sense_pull_sel = 2'h0;
            io_pull_sel    = 2'h0;
        end
    end

    assign SENSE_PULL_EN = sense_pull_sel;
    assign IO_PULL_EN    = io_pull_sel;

    // ----------------------------------------
    // input gating
    // ----------------------------------------
    // bit 0 is the sense pin, bit 1 the io pin
    wire [1:0] pin_raw;
    wire [1:0] pin_sync;
    genvar     gi;

    assign pin_raw = {FAIL_OUTPUT_IO_PIN_I, HV_SENSE_PIN};

    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            hvms_sync u_pin_sync (
                .clk       (REF_CLK),
                .rst_n     (RESET_N),
                .pin_in    (pin_raw[gi]),
                .level_out (pin_sync[gi])
            );
        end
    endgenerate

    // pins still see the divider node, so gate after the sync
    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SENSE_LEVEL <= 1'h0;
            IO_LEVEL    <= 1'h0;
        end else begin
            SENSE_LEVEL <= pin_sync[0] & ~measure_enable_reg;
            IO_LEVEL    <= pin_sync[1] & ~measure_enable_reg;
        end
    end

    // ----------------------------------------
    // wake sources
    // ----------------------------------------
    reg sense_wake_sel;
    reg io_wake_sel;

    assign WAKE_STATUS_UPDATE_EN = ~measure_enable_reg;

    always @* begin
        sense_wake_sel = SENSE_WAKE_ENABLE;
        io_wake_sel    = io_wake;
        // fail-safe forces the sense wake only when measurement is off
        if (is_fsafe)
            sense_wake_sel = 1'h1;
        if (measure_enable_reg) begin
            // wake bits stay writable but lose to measurement
            sense_wake_sel = 1'h0;
            io_wake_sel    = 1'h0;
        end
    end

    assign SENSE_WAKE_ACTIVE = sense_wake_sel;
    assign IO_WAKE_ACTIVE    = io_wake_sel;

    // ----------------------------------------
    // pin output
    // ----------------------------------------
    reg io_o_sel;
    reg io_oe_sel;

    always @* begin
        io_o_sel  = IO_OUT_REQ;
        io_oe_sel = 1'h0;
        case (IOCFG_CUR)
            `HVMS_IOCFG_FAIL: begin
                // open-drain fail output, low while driven
                io_o_sel  = 1'h0;
                io_oe_sel = FAIL_OUTPUT_REQ | FAIL_OUTPUT_TEST;
            end
            `HVMS_IOCFG_OFF: begin
                io_oe_sel = 1'h0;
            end
            `HVMS_IOCFG_WAKE: begin
                io_oe_sel = 1'h0;
            end
            default: begin
                io_oe_sel = 1'h1;
            end
        endcase
        if (measure_enable_reg) begin
            io_o_sel  = 1'h0;
            io_oe_sel = 1'h0;
        end
    end

    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FAIL_OUTPUT_IO_PIN_O  <= 1'h0;
            FAIL_OUTPUT_IO_PIN_OE <= 1'h0;
        end else begin
            FAIL_OUTPUT_IO_PIN_O  <= io_o_sel;
            FAIL_OUTPUT_IO_PIN_OE <= io_oe_sel;
        end
    end

    // ----------------------------------------
    // error flag and sleep refusal
    // ----------------------------------------
    // error events only: the sticky flag lives with the spi registers
    wire only_pin_wake = ~OTHER_WAKE_SRC & (SENSE_WAKE_ENABLE | io_wake);
    wire io_change     = IOCFG_WR & (IOCFG_WR_DATA != IOCFG_CUR);
    wire sleep_bad     = measure_enable_reg & SLEEP_CMD & only_pin_wake;
    reg  fail_evt;

    always @* begin
        fail_evt = 1'h0;
        if (refuse)
            fail_evt = 1'h1;
        if (measure_enable_reg && io_change)
            fail_evt = 1'h1;
        if (sleep_bad)
            fail_evt = 1'h1;
    end

    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SPI_FAIL_SET <= 1'h0;
            RESTART_REQ  <= 1'h0;
        end else begin
            SPI_FAIL_SET <= fail_evt;
            RESTART_REQ  <= sleep_bad;
        end
    end
endmodule

// ==== tb/hvms_ctrl_props.sv ====
// port assertions for the measurement switch control block
module hvms_ctrl_props (
    // clock and reset
    input wire logic       REF_CLK,
    input wire logic       RESET_N,
    // requests and settings
    input wire logic [2:0] CHIP_MODE,
    input wire logic       MEAS_WR,
    input wire logic       MEAS_WR_DATA,
    input wire logic       IOCFG_WR,
    input wire logic [2:0] IOCFG_WR_DATA,
    input wire logic [2:0] IOCFG_CUR,
    input wire logic       SENSE_WAKE_ENABLE,
    input wire logic       OTHER_WAKE_SRC,
    input wire logic       SLEEP_CMD,
    // results
    input wire logic       MEASURE_SWITCH,
    input wire logic [1:0] SENSE_PULL_EN,
    input wire logic [1:0] IO_PULL_EN,
    input wire logic       FAIL_OUTPUT_IO_PIN_OE,
    input wire logic       SENSE_LEVEL,
    input wire logic       WAKE_STATUS_UPDATE_EN,
    input wire logic       SENSE_WAKE_ACTIVE,
    input wire logic       MEASURE_ENABLE,
    input wire logic       SPI_FAIL_SET,
    input wire logic       RESTART_REQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_on_req; MEAS_WR && MEAS_WR_DATA; endsequence
    property p_sw; MEASURE_SWITCH == (MEASURE_ENABLE && CHIP_MODE == 3'h0);
    endproperty
    a_sw: assert property (p_sw) else $error("switch wrong");
    property p_pull; MEASURE_ENABLE |-> SENSE_PULL_EN == 2'h0
        && IO_PULL_EN == 2'h0; endproperty
    a_pull: assert property (p_pull) else $error("pull on");
    property p_gate; MEASURE_ENABLE && $past(MEASURE_ENABLE)
        |-> !SENSE_LEVEL && !FAIL_OUTPUT_IO_PIN_OE; endproperty
    a_gate: assert property (p_gate) else $error("pin live");
    property p_wake; MEASURE_ENABLE |-> !WAKE_STATUS_UPDATE_EN
        && !SENSE_WAKE_ACTIVE; endproperty
    a_wake: assert property (p_wake) else $error("wake live");
    property p_on; s_on_req ##0 IOCFG_CUR == 3'h4 |=> MEASURE_ENABLE;
    endproperty
    a_on: assert property (p_on) else $error("enable lost");
    property p_ref; s_on_req ##0 (!MEASURE_ENABLE && IOCFG_CUR != 3'h4)
        |=> !MEASURE_ENABLE && SPI_FAIL_SET; endproperty
    a_ref: assert property (p_ref) else $error("no refusal");
    property p_slp; MEASURE_ENABLE && SLEEP_CMD && SENSE_WAKE_ENABLE
        && !OTHER_WAKE_SRC |=> SPI_FAIL_SET && RESTART_REQ; endproperty
    a_slp: assert property (p_slp) else $error("sleep taken");
    property p_cfg; MEASURE_ENABLE && IOCFG_WR
        && IOCFG_WR_DATA != IOCFG_CUR |=> SPI_FAIL_SET; endproperty
    a_cfg: assert property (p_cfg) else $error("no cfg error");
    property p_keep; CHIP_MODE != 3'h0 && !MEAS_WR
        |=> $stable(MEASURE_ENABLE); endproperty
    a_keep: assert property (p_keep) else $error("enable lost");
    property p_fs; !MEASURE_ENABLE && CHIP_MODE == 3'h4
        |-> SENSE_WAKE_ACTIVE; endproperty
    a_fs: assert property (p_fs) else $error("no wake");
endmodule

// ==== tb/hvms_pin_model.sv ====
// far side: battery level on the sense pin, divider node on the io pin
module hvms_pin_model (
    input  wire logic batt_hi,
    input  wire logic sw_closed,
    input  wire logic io_oe,
    input  wire logic io_o,
    output logic      sense_pin,
    output logic      io_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    assign sense_pin = batt_hi;
    // divider pulls the node low when nothing drives it
    assign io_pin = sw_closed ? batt_hi : (io_oe ? io_o : 1'h0);
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the measurement switch control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic REF_CLK = 0, RESET_N = 0, MEAS_WR = 0, MEAS_WR_DATA = 0;
    logic IOCFG_WR = 0, SENSE_WAKE_ENABLE = 1, FAIL_OUTPUT_REQ = 1;
    logic FAIL_OUTPUT_TEST = 1, IO_OUT_REQ = 1, OTHER_WAKE_SRC = 0;
    logic SLEEP_CMD = 0, batt_hi = 0;
    logic [2:0] CHIP_MODE = 3'h0, IOCFG_WR_DATA = 3'h0, IOCFG_CUR = 3'h4;
    logic [1:0] SENSE_PULL_CFG = 2'h3, IO_PULL_CFG = 2'h2;
    logic [1:0] SENSE_PULL_EN, IO_PULL_EN;
    logic MEASURE_SWITCH, FAIL_OUTPUT_IO_PIN_O, FAIL_OUTPUT_IO_PIN_OE;
    logic SENSE_LEVEL, IO_LEVEL, WAKE_STATUS_UPDATE_EN, SENSE_WAKE_ACTIVE;
    logic IO_WAKE_ACTIVE, MEASURE_ENABLE, SPI_FAIL_SET, RESTART_REQ;
    logic HV_SENSE_PIN, FAIL_OUTPUT_IO_PIN_I;
    int n_fail = 0;
    int checks_done = 0;
    always #2.5 REF_CLK = ~REF_CLK;
    hvms_ctrl u_hvms_ctrl (.REF_CLK, .RESET_N, .CHIP_MODE, .MEAS_WR,
        .MEAS_WR_DATA, .IOCFG_WR, .IOCFG_WR_DATA, .IOCFG_CUR,
        .SENSE_WAKE_ENABLE, .SENSE_PULL_CFG, .IO_PULL_CFG, .FAIL_OUTPUT_REQ,
        .FAIL_OUTPUT_TEST, .IO_OUT_REQ, .OTHER_WAKE_SRC, .SLEEP_CMD,
        .HV_SENSE_PIN, .FAIL_OUTPUT_IO_PIN_I, .MEASURE_SWITCH, .SENSE_PULL_EN,
        .IO_PULL_EN, .FAIL_OUTPUT_IO_PIN_O, .FAIL_OUTPUT_IO_PIN_OE,
        .SENSE_LEVEL, .IO_LEVEL, .WAKE_STATUS_UPDATE_EN, .SENSE_WAKE_ACTIVE,
        .IO_WAKE_ACTIVE, .MEASURE_ENABLE, .SPI_FAIL_SET, .RESTART_REQ);
    hvms_pin_model u_hvms_pin_model (.batt_hi, .sw_closed(MEASURE_SWITCH),
        .io_oe(FAIL_OUTPUT_IO_PIN_OE), .io_o(FAIL_OUTPUT_IO_PIN_O),
        .sense_pin(HV_SENSE_PIN), .io_pin(FAIL_OUTPUT_IO_PIN_I));
    task automatic chk(input string nm, input logic [2:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge REF_CLK);
    endtask
    // one-cycle request; the answer stands in the cycle that follows
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #20000;
        n_fail++;
        report_and_stop;
    end
    initial begin
        cyc(10);
        RESET_N = 1;
        batt_hi = 1;
        cyc(5);
        chk("switch", MEASURE_SWITCH, 3'h0);
        chk("pull", SENSE_PULL_EN, 3'h3);
        chk("level", SENSE_LEVEL, 3'h1);
        MEAS_WR_DATA = 1;
        for (int c = 0; c < 8; c++) if (c != 4) begin
            IOCFG_CUR = c[2:0];
            pulse(MEAS_WR);
            chk("refused", MEASURE_ENABLE, 3'h0);
            chk("fail", SPI_FAIL_SET, 3'h1);
            chk("io drive", FAIL_OUTPUT_IO_PIN_OE, {2'h0, c != 5});
            chk("io out", FAIL_OUTPUT_IO_PIN_O, {2'h0, c != 0});
            chk("io wake", IO_WAKE_ACTIVE, {2'h0, c == 5});
            cyc(1);
        end
        IOCFG_CUR = 3'h4;
        pulse(MEAS_WR);
        chk("enable", MEASURE_ENABLE, 3'h1);
        chk("switch", MEASURE_SWITCH, 3'h1);
        chk("pull", {1'b0, SENSE_PULL_EN} | {1'b0, IO_PULL_EN}, 3'h0);
        chk("status", WAKE_STATUS_UPDATE_EN, 3'h0);
        chk("wake", SENSE_WAKE_ACTIVE | IO_WAKE_ACTIVE, 3'h0);
        cyc(5);
        chk("gated", SENSE_LEVEL | IO_LEVEL, 3'h0);
        chk("io drive", FAIL_OUTPUT_IO_PIN_OE, 3'h0);
        chk("io out", FAIL_OUTPUT_IO_PIN_O, 3'h0);
        chk("divider", FAIL_OUTPUT_IO_PIN_I, 3'h1);
        pulse(IOCFG_WR);
        chk("cfg fail", SPI_FAIL_SET, 3'h1);
        pulse(SLEEP_CMD);
        chk("sleep fail", SPI_FAIL_SET & RESTART_REQ, 3'h1);
        SENSE_WAKE_ENABLE = 0;
        IOCFG_CUR = 3'h5;
        pulse(SLEEP_CMD);
        chk("sleep io", SPI_FAIL_SET & RESTART_REQ, 3'h1);
        chk("io wake", IO_WAKE_ACTIVE, 3'h0);
        OTHER_WAKE_SRC = 1;
        pulse(SLEEP_CMD);
        chk("sleep ok", SPI_FAIL_SET | RESTART_REQ, 3'h0);
        OTHER_WAKE_SRC = 0;
        IOCFG_CUR = 3'h4;
        for (int m = 1; m < 6; m++) begin
            CHIP_MODE = m[2:0];
            cyc(1);
            chk("open", MEASURE_SWITCH, 3'h0);
            chk("kept", MEASURE_ENABLE, 3'h1);
        end
        CHIP_MODE = 3'h0;
        MEAS_WR_DATA = 0;
        pulse(MEAS_WR);
        chk("pull back", SENSE_PULL_EN, 3'h3);
        CHIP_MODE = 3'h4;
        SENSE_WAKE_ENABLE = 0;
        cyc(1);
        chk("safe wake", SENSE_WAKE_ACTIVE, 3'h1);
        report_and_stop;
    end
endmodule
bind hvms_ctrl hvms_ctrl_props u_hvms_ctrl_props (.REF_CLK, .RESET_N,
    .CHIP_MODE, .MEAS_WR, .MEAS_WR_DATA, .IOCFG_WR, .IOCFG_WR_DATA,
    .IOCFG_CUR, .SENSE_WAKE_ENABLE, .OTHER_WAKE_SRC, .SLEEP_CMD,
    .MEASURE_SWITCH, .SENSE_PULL_EN, .IO_PULL_EN, .FAIL_OUTPUT_IO_PIN_OE,
    .SENSE_LEVEL, .WAKE_STATUS_UPDATE_EN, .SENSE_WAKE_ACTIVE,
    .MEASURE_ENABLE, .SPI_FAIL_SET, .RESTART_REQ);
